// ===== hw/adf_params.svh
// constants of the converter output demultiplexer and formatter
// assumes inclusion by bare name from the formatter package and design file
// Functional notes
// [R1] ratio select 0 gives two ports, 1 four
// [R2] full-rate clock quarter rate, rising edge centred
// [R3] half-rate clock eighth rate, both edges centred
// [R4] clock type 1 full-rate, 0 half-rate
// [R5] staggered ports one by one, simultaneous together
// [R6] staggered select low staggered, high simultaneous
// [R7] staggered range pins carry per-port data clocks
// [R8] simultaneous range pin flags over or underflow
// [R9] overrange forces all ones, underrange all zeros
// [R10] global clock equals last used port clock
// [R11] sleep low freezes outputs, high resumes
// [R12] sleep, staggered, self-test inputs active low
// [R13] self test outputs inverting checkerboard words
// [R14] four-way test sequence with inverse repeat
// [R15] two-way test sequence with swap repeat
// [R16] far side resets before trusting test sequence
// [R17] demux reset aligns samples to A,B,C,D
// [R18] two-way split leaves ports C, D unused
`ifndef ADF_PARAMS_SVH
`define ADF_PARAMS_SVH

`define ADF_CODE_W 10
`define ADF_SAMPLE_W 12
`define ADF_FIFO_DEPTH 32
`define ADF_SYNC_W 19
`define ADF_PAT_EVEN 10'h2AA
`define ADF_PAT_ODD 10'h155
`define ADF_CODE_MAX 10'h3FF
`define ADF_CODE_MIN 10'h000
`define ADF_LAST_FOUR 2'h3
`define ADF_LAST_TWO 2'h1
`define ADF_HALF_FOUR 2'h2
`define ADF_HALF_TWO 2'h1
`define ADF_PHASE_ZERO 2'h0
`define ADF_REG_CTRL 2'h0
`define ADF_REG_STATUS 2'h1
`define ADF_WORD_ZERO 32'h00000000
`define ADF_LANES 4

`endif

// ===== hw/adf_pkg.sv
// types used by the output formatter; its fifo takes plain bit vectors
// assumes the constants header sits beside it
`default_nettype none
`include "adf_params.svh"

package adf_pkg;

    // one converter sample with its range flags
    typedef struct packed {
        logic over_pos;
        logic over_neg;
        logic [`ADF_CODE_W-1:0] code;
    } adf_sample_s;

    // one formatted output word
    typedef struct packed {
        logic range_flag;
        logic [`ADF_CODE_W-1:0] code;
    } adf_word_s;

    // synchronised static mode pins, active-low ones keep their polarity
    typedef struct packed {
        logic sleep_n;
        logic staggered_n;
        logic self_test_n;
        logic ratio_four;
        logic clock_full;
    } adf_mode_s;

    // control register layout
    typedef struct packed {
        logic [30:0] reserved;
        logic realign;
    } adf_ctrl_s;

    // status register layout
    typedef struct packed {
        logic [16:0] reserved;
        adf_mode_s mode;
        logic [5:0] level;
        logic group_odd;
        logic [1:0] phase;
        logic dropped;
    } adf_status_s;

endpackage

`default_nettype wire

// ===== hw/adf_output_formatter.sv
// output demultiplexer and data clock generator with its input fifo
// assumes one 200 MHz clock; converter sample clock, sample and mode pins arrive asynchronously
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`include "adf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module adf_fifo #(
    parameter int WIDTH = `ADF_SAMPLE_W,
    parameter int DEPTH = `ADF_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // occupancy
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] next_level;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // occupancy after this cycle
    always_comb begin
        next_level = level;
        if (push && !pop) begin
            next_level = level + 1'b1;
        end else if (pop && !push) begin
            next_level = level - 1'b1;
        end
    end

    // flags registered from the next level so they are honest the same cycle they change
    always_ff @(posedge clock) begin
        if (!resetn) begin
            level <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            level <= next_level;
            in_ready <= next_level != (AW+1)'(DEPTH);
            out_valid <= next_level != '0;
        end
    end

    // pointers wrap naturally, depth is a power of two
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // storage, no reset needed
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

module adf_output_formatter (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // converter core side
    input wire logic sample_clock,
    input wire logic [`ADF_CODE_W-1:0] sample_code,
    input wire logic sample_over_pos,
    input wire logic sample_over_neg,
    output logic sample_accept,
    // static mode pins
    input wire logic split_ratio_select,
    input wire logic out_clock_type_select,
    input wire logic staggered_select_n,
    input wire logic sleep_select_n,
    input wire logic self_test_n,
    input wire logic demux_async_reset,
    // output ports
    output logic [`ADF_CODE_W-1:0] port_a_data,
    output logic [`ADF_CODE_W-1:0] port_b_data,
    output logic [`ADF_CODE_W-1:0] port_c_data,
    output logic [`ADF_CODE_W-1:0] port_d_data,
    output logic port_a_range_or_strobe,
    output logic port_b_range_or_strobe,
    output logic port_c_range_or_strobe,
    output logic port_d_range_or_strobe,
    output logic global_data_ready_clock,
    // avalon-mm register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    logic [`ADF_SYNC_W-1:0] pin_meta;
    logic [`ADF_SYNC_W-1:0] pin_sync;
    logic sample_clock_d;
    logic demux_reset_s;
    logic sample_clock_s;
    adf_pkg::adf_mode_s mode;
    adf_pkg::adf_sample_s pin_sample;
    adf_pkg::adf_sample_s fifo_sample;
    logic [`ADF_SAMPLE_W-1:0] fifo_out_bits;
    logic fifo_out_valid;
    logic [5:0] fifo_level;
    logic tick;
    logic awake;
    logic test_on;
    logic staggered;
    logic step;
    logic realign;
    logic soft_realign;
    logic dropped;
    logic [1:0] phase;
    logic group_odd;
    logic [1:0] last;
    logic [`ADF_LANES-1:0] lane_clk;
    logic [`ADF_LANES-1:0] next_lane_clk;
    logic [`ADF_CODE_W-1:0] port_word [`ADF_LANES];
    logic [`ADF_LANES-1:0] range_pin;
    adf_pkg::adf_word_s shadow [`ADF_LANES];
    adf_pkg::adf_word_s cur_word;
    adf_pkg::adf_status_s status;
    adf_pkg::adf_ctrl_s ctrl_wr;
    logic bus_done;

    // mid-word phase of a lane: half a word after its own load
    function automatic logic [1:0] mid_of(input logic [1:0] k, input logic four);
        logic [1:0] m;
        m = four ? (k + `ADF_HALF_FOUR) : {1'b0, ~k[0]};
        return m;
    endfunction

    // formatted word: checkerboard in test, clamped code otherwise
    function automatic adf_pkg::adf_word_s make_word(input adf_pkg::adf_sample_s s,
                                                     input logic test, input logic inv);
        adf_pkg::adf_word_s w;
        w.range_flag = s.over_pos || s.over_neg;
        w.code = s.code;
        if (test) begin
            w.code = inv ? `ADF_PAT_ODD : `ADF_PAT_EVEN;
            w.range_flag = inv;
        end else if (s.over_pos) begin
            w.code = `ADF_CODE_MAX;
        end else if (s.over_neg) begin
            w.code = `ADF_CODE_MIN;
        end
        return w;
    endfunction

    // every asynchronous pin passes two flops before anything reads it
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
            sample_clock_d <= 1'b0;
        end else begin
            pin_meta <= {demux_async_reset, sleep_select_n, staggered_select_n, self_test_n,
                         split_ratio_select, out_clock_type_select, sample_clock,
                         sample_over_pos, sample_over_neg, sample_code};
            pin_sync <= pin_meta;
            sample_clock_d <= sample_clock_s;
        end
    end

    assign {demux_reset_s, mode, sample_clock_s, pin_sample} = pin_sync;
    assign fifo_sample = adf_pkg::adf_sample_s'(fifo_out_bits);

    // the converter must hold its sample for a few system clocks around its clock edge,
    // since data and clock are sampled with the same two-flop latency
    assign tick = sample_clock_s && !sample_clock_d;
    assign awake = mode.sleep_n;                 // [R11] [R12]
    assign test_on = !mode.self_test_n;          // [R12]
    assign staggered = !mode.staggered_n;        // [R6] [R12]
    assign last = mode.ratio_four ? `ADF_LAST_FOUR : `ADF_LAST_TWO; // [R1]
    assign realign = demux_reset_s || soft_realign;
    // asleep nothing advances, the fifo backs up and refuses new samples
    assign step = tick && awake && (test_on || fifo_out_valid);
    assign cur_word = make_word(fifo_sample, test_on, phase[0] ^ group_odd); // [R9] [R13]

    // sample buffer between the converter and the output stage
    adf_fifo #(
        .WIDTH(`ADF_SAMPLE_W),
        .DEPTH(`ADF_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_valid(tick),
        .in_data(pin_sample),
        .in_ready(sample_accept),
        .out_valid(fifo_out_valid),
        .out_ready(tick && awake),
        .out_data(fifo_out_bits),
        .level(fifo_level)
    );

    // port sequencing: phase picks the port, group parity inverts the test pattern
    always_ff @(posedge clock) begin
        if (!resetn || realign) begin
            phase <= `ADF_PHASE_ZERO;                    // [R17]
            group_odd <= 1'b0;
        end else if (step) begin
            if (phase >= last) begin
                phase <= `ADF_PHASE_ZERO;
                group_odd <= !group_odd;                 // [R14] [R15]
            end else begin
                phase <= phase + 1'b1;                   // [R1] [R17]
            end
        end
    end

    // per-lane data clocks, low at load and high mid-word in full rate, toggled mid-word in half rate
    always_comb begin
        for (int k = 0; k < `ADF_LANES; k++) begin
            next_lane_clk[k] = lane_clk[k];
            if (2'(k) > last) begin
                next_lane_clk[k] = 1'b0;                 // [R18]
            end else if (mode.clock_full) begin          // [R4]
                if (phase == 2'(k)) begin
                    next_lane_clk[k] = 1'b0;             // [R2]
                end else if (phase == mid_of(2'(k), mode.ratio_four)) begin
                    next_lane_clk[k] = 1'b1;             // [R2]
                end
            end else if (phase == mid_of(2'(k), mode.ratio_four)) begin
                next_lane_clk[k] = !lane_clk[k];         // [R3]
            end
        end
    end

    // lane clocks and the global clock, which is the last used lane clock
    always_ff @(posedge clock) begin
        if (!resetn || realign) begin
            lane_clk <= '0;
            global_data_ready_clock <= 1'b0;
        end else if (step) begin
            lane_clk <= next_lane_clk;
            global_data_ready_clock <= next_lane_clk[last]; // [R10]
        end
    end

    // shadow words collect a group for simultaneous release
    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int k = 0; k < `ADF_LANES; k++) begin
                shadow[k] <= '0;
            end
        end else if (step) begin
            shadow[phase] <= cur_word;
        end
    end

    // output words and range-or-strobe pins, untouched while asleep
    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int k = 0; k < `ADF_LANES; k++) begin
                port_word[k] <= '0;
            end
            range_pin <= '0;
        end else if (step) begin
            for (int k = 0; k < `ADF_LANES; k++) begin
                if (2'(k) > last) begin
                    port_word[k] <= '0;                  // [R18]
                    range_pin[k] <= 1'b0;
                end else if (staggered) begin
                    range_pin[k] <= next_lane_clk[k];    // [R7]
                    if (phase == 2'(k)) begin
                        port_word[k] <= cur_word.code;   // [R5]
                    end
                end else if (phase == last) begin
                    port_word[k] <= (2'(k) == last) ? cur_word.code : shadow[k].code; // [R5]
                    range_pin[k] <= (2'(k) == last) ? cur_word.range_flag : shadow[k].range_flag; // [R8]
                end
            end
        end
    end

    assign port_a_data = port_word[0];
    assign port_b_data = port_word[1];
    assign port_c_data = port_word[2];
    assign port_d_data = port_word[3];
    assign port_a_range_or_strobe = range_pin[0];
    assign port_b_range_or_strobe = range_pin[1];
    assign port_c_range_or_strobe = range_pin[2];
    assign port_d_range_or_strobe = range_pin[3];

    // bus slave: one wait state on every access, answer on the second cycle
    assign bus_done = (avs_read || avs_write) && !avs_waitrequest;
    assign ctrl_wr = adf_pkg::adf_ctrl_s'(avs_writedata);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    // status snapshot, unmapped offsets read zero
    always_comb begin
        status = '0;
        status.mode = mode;
        status.level = fifo_level;
        status.group_odd = group_odd;
        status.phase = phase;
        status.dropped = dropped;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            avs_readdata <= `ADF_WORD_ZERO;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= (avs_address[3:2] == `ADF_REG_STATUS) ? status : `ADF_WORD_ZERO;
        end
    end

    // realign pulse from software, one cycle per accepted control write with the realign bit set
    always_ff @(posedge clock) begin
        if (!resetn) begin
            soft_realign <= 1'b0;
        end else begin
            soft_realign <= bus_done && avs_write && avs_byteenable[0]
                && avs_address[3:2] == `ADF_REG_CTRL && ctrl_wr.realign;
        end
    end

    // sticky drop flag, a new drop in the clearing cycle wins over the clear
    always_ff @(posedge clock) begin
        if (!resetn) begin
            dropped <= 1'b0;
        end else if (tick && !sample_accept) begin
            dropped <= 1'b1;
        end else if (bus_done && avs_write && avs_byteenable[0]
                     && avs_address[3:2] == `ADF_REG_STATUS && avs_writedata[0]) begin
            dropped <= 1'b0;
        end
    end

    // checks on the formatter
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_last_step;
        step && phase == last && !realign;
    endsequence

    sequence s_mid_step;
        step && phase == mid_of(last, mode.ratio_four) && !realign;
    endsequence

    realign_phase_a: assert property (demux_reset_s |=> phase == `ADF_PHASE_ZERO && !group_odd) // [R17]
        else $error("demux reset did not realign phase");
    four_way_count_a: assert property (step && mode.ratio_four && phase == 2'h2 && !realign // [R1]
                                       && $stable(mode) |=> phase == `ADF_LAST_FOUR)
        else $error("four-way split skipped a port");
    full_rate_low_a: assert property (mode.clock_full ##0 s_last_step |=> !global_data_ready_clock) // [R2]
        else $error("full-rate clock not low at word change");
    half_rate_toggle_a: assert property (!mode.clock_full ##0 s_mid_step // [R3]
                                         |=> global_data_ready_clock != $past(global_data_ready_clock))
        else $error("half-rate clock did not toggle mid-word");
    // a ratio change moves the last lane before the next step, so only settled steps are judged
    global_is_last_a: assert property ((step && !realign) ##1 $stable(mode) // [R10]
        |-> global_data_ready_clock == lane_clk[last])
        else $error("global clock differs from last port clock");
    sleep_freeze_a: assert property (!awake |=> $stable(port_a_data) && $stable(port_a_range_or_strobe)) // [R11]
        else $error("outputs moved while asleep");
    unused_ports_a: assert property (step && !mode.ratio_four |=> port_c_data == '0 && port_d_data == '0) // [R18]
        else $error("ports C or D active in two-way split");
    staggered_select_n_strobe_a: assert property (step && staggered && !realign |=> port_a_range_or_strobe == lane_clk[0]) // [R7]
        else $error("staggered strobe not the lane clock");
    overrange_a: assert property (step && staggered && !test_on && phase == `ADF_PHASE_ZERO // [R9]
                                  && fifo_sample.over_pos |=> port_a_data == `ADF_CODE_MAX)
        else $error("overrange did not force all ones");
    test_pattern_a: assert property (step && staggered && test_on && phase == `ADF_PHASE_ZERO // [R13] [R14] [R15]
                                     && !group_odd |=> port_a_data == `ADF_PAT_EVEN)
        else $error("test pattern wrong on port A");
    // judged against the raw range bits of the popped sample, not the formatted word
    simul_flag_a: assert property (!staggered && !test_on && mode.ratio_four ##0 s_last_step // [R8]
        |=> port_d_range_or_strobe == $past(fifo_sample.over_pos || fifo_sample.over_neg))
        else $error("simultaneous range flag wrong");
endmodule

`default_nettype wire

// ===== dv/adf_capture_model.sv
// receiving logic model: latches formatter words on the data clock edges
// assumes it shares the system clock and sees the mode pins of the bench
`include "adf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module adf_capture_model (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // receiver setup
    input wire logic ratio_four,
    input wire logic clock_full,
    input wire logic staggered_n,
    // formatter outputs, index 0 is port a
    input wire logic [3:0][`ADF_CODE_W-1:0] port_data,
    input wire logic [3:0] strobe,
    input wire logic global_clock
);
    logic [3:0] prev_strobe;
    logic prev_global;
    logic [`ADF_CODE_W+2:0] words[$];
    int global_rises = 0;
    int alias_errs = 0;
    wire [2:0] lanes = ratio_four ? 3'h4 : 3'h2;

    // words are {port, flag, code}; half-rate takes both edges, so a missed edge loses a word
    always @(posedge clock) begin
        prev_strobe <= strobe;
        prev_global <= global_clock;
        if (resetn && global_clock && !prev_global) begin
            global_rises++;
        end
        if (resetn && staggered_n && global_clock !== prev_global && (global_clock || !clock_full)) begin
            for (int k = 0; k < lanes; k++) begin
                words.push_back({k[1:0], strobe[k], port_data[k]});
            end
        end
        if (resetn && !staggered_n) begin
            for (int k = 0; k < lanes; k++) begin
                if (strobe[k] !== prev_strobe[k] && (strobe[k] || !clock_full)) begin
                    words.push_back({k[1:0], 1'b0, port_data[k]});
                end
            end
            if (global_clock !== strobe[lanes-1]) begin
                alias_errs++;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// bench for the output formatter: streams, modes, self test, sleep, fifo and registers
// assumes the formatter and the capture model are compiled first
`include "adf_params.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", name, exp, got); end end

module tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic sample_clock = 1'b0;
    logic [9:0] sample_code = 10'h000;
    logic sample_over_pos = 1'b0;
    logic sample_over_neg = 1'b0;
    logic split_ratio_select = 1'b1;
    logic out_clock_type_select = 1'b1;
    logic staggered_select_n = 1'b1;
    logic sleep_select_n = 1'b1;
    logic self_test_n = 1'b1;
    logic demux_async_reset = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sample_accept;
    logic [3:0][9:0] port_data;
    logic [3:0] strobe;
    logic global_data_ready_clock;
    logic [31:0] rd;
    int err_total = 0;
    int samples_checked = 0;

    // 200 MHz system clock
    always #2.5 clock = ~clock;

    adf_output_formatter i_dut (.clock, .resetn, .sample_clock, .sample_code, .sample_over_pos,
        .sample_over_neg, .sample_accept, .split_ratio_select, .out_clock_type_select,
        .staggered_select_n, .sleep_select_n, .self_test_n, .demux_async_reset,
        .port_a_data(port_data[0]), .port_b_data(port_data[1]), .port_c_data(port_data[2]),
        .port_d_data(port_data[3]), .port_a_range_or_strobe(strobe[0]), .port_b_range_or_strobe(strobe[1]),
        .port_c_range_or_strobe(strobe[2]), .port_d_range_or_strobe(strobe[3]), .global_data_ready_clock,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);

    adf_capture_model i_cap (.clock, .resetn, .ratio_four(split_ratio_select),
        .clock_full(out_clock_type_select), .staggered_n(staggered_select_n), .port_data,
        .strobe, .global_clock(global_data_ready_clock));

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one access; the request stands until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
        @(posedge clock);
        avs_address <= addr;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= wdata;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // one converter sample; code stays put well around the sample clock rise
    task automatic sample(input logic [9:0] code, input logic pos, input logic neg);
        sample_code <= code;
        sample_over_pos <= pos;
        sample_over_neg <= neg;
        tick(8);
        sample_clock <= 1'b1;
        tick(16);
        sample_clock <= 1'b0;
        tick(8);
    endtask

    // realign by pin or register, then phase and group must read zero
    task automatic realign(input logic by_reg);
        if (by_reg) begin
            bus(1'b1, 4'h0, 32'h00000001);
        end else begin
            demux_async_reset <= 1'b1;
            tick(6);
            demux_async_reset <= 1'b0;
        end
        tick(6);
        bus(1'b0, 4'h4, 32'h00000000);
        `CHK("phase group", 3'h0, rd[3:1])
    endtask

    // stream distinct codes with an overrange pair; stale words are skipped by anchoring
    task automatic run_check(input logic four, input logic full, input logic stag_n, input logic [9:0] base);
        logic [9:0] exp_q[$];
        logic [12:0] w;
        int k, p0, lanes, e, d;
        split_ratio_select <= four;
        out_clock_type_select <= full;
        staggered_select_n <= stag_n;
        tick(4);
        realign(1'b0);
        i_cap.words.delete();
        e = i_cap.global_rises;
        lanes = four ? 4 : 2;
        for (int i = 0; i < 36; i++) begin
            exp_q.push_back(i == 5 ? 10'h3FF : i == 6 ? 10'h000 : base + 10'(i));
            sample(base + 10'(i), i == 5, i == 6);
            if (i == 4) i_cap.alias_errs = 0;
        end
        d = i_cap.global_rises - e;
        e = 36 / (lanes * (full ? 1 : 2));
        `CHK("clock rate", 1'b1, d >= e - 1 && d <= e + 1)
        k = 0;
        while (k < i_cap.words.size() && i_cap.words[k][9:0] !== exp_q[0]) k++;
        `CHK("words seen", 1'b1, k + 24 <= i_cap.words.size())
        p0 = i_cap.words[k][12:11];
        for (int i = 0; i < 24 && k + i < i_cap.words.size(); i++) begin
            w = i_cap.words[k + i];
            `CHK("port word", exp_q[i], w[9:0])
            `CHK("port order", 2'((p0 + i) % lanes), w[12:11])
            if (stag_n) `CHK("range flag", i == 5 || i == 6, w[10])
        end
        if (!stag_n) `CHK("global alias", 0, i_cap.alias_errs)
        if (!four) `CHK("unused ports", 20'h00000, {port_data[3], port_data[2]})
    endtask

    // checkerboard: alternate within a group, invert group to group
    task automatic self_test(input logic four, input logic full);
        logic [12:0] a, b;
        int lanes;
        split_ratio_select <= four;
        out_clock_type_select <= full;
        self_test_n <= 1'b0;
        staggered_select_n <= 1'b1; // flags only travel on the range pins in simultaneous mode
        tick(4);
        realign(1'b1);
        i_cap.words.delete();
        lanes = four ? 4 : 2;
        repeat (24) sample(10'h0AB, 1'b0, 1'b0);
        `CHK("test words", 1'b1, i_cap.words.size() >= 12)
        for (int i = lanes; i + lanes < i_cap.words.size(); i++) begin
            a = i_cap.words[i];
            b = i_cap.words[i + lanes];
            `CHK("test flag", a[10] ? 10'h155 : 10'h2AA, a[9:0])
            `CHK("test checker", i_cap.words[i - i % lanes][9:0] ^ {10{a[11]}}, a[9:0])
            `CHK("test invert", a[9:0] ^ 10'h3FF, b[9:0])
        end
        self_test_n <= 1'b1;
    endtask

    // sleep freezes the ports while the fifo fills until it refuses
    task automatic sleep_and_fill();
        logic [9:0] held;
        int n;
        split_ratio_select <= 1'b1;
        out_clock_type_select <= 1'b1;
        tick(4);
        bus(1'b0, 4'h4, 32'h00000000);
        `CHK("mode pins", 5'h1F, rd[14:10])
        sleep_select_n <= 1'b0;
        repeat (2) sample(10'h0C3, 1'b0, 1'b0);
        held = port_data[0];
        n = i_cap.words.size();
        repeat (40) sample(10'h0C3, 1'b0, 1'b0);
        `CHK("frozen port", held, port_data[0])
        `CHK("frozen capture", n, i_cap.words.size())
        `CHK("fifo refuses", 1'b0, sample_accept)
        bus(1'b0, 4'h4, 32'h00000000);
        `CHK("sleep pin", 5'h0F, rd[14:10])
        `CHK("fifo level", 6'h20, rd[9:4])
        `CHK("dropped", 1'b1, rd[0])
        bus(1'b1, 4'h4, 32'h00000001);
        bus(1'b0, 4'h4, 32'h00000000);
        `CHK("dropped clear", 1'b0, rd[0])
        bus(1'b1, 4'h8, 32'hFFFFFFFF);
        bus(1'b0, 4'h8, 32'h00000000);
        `CHK("unmapped read", 32'h00000000, rd)
        bus(1'b0, 4'h0, 32'h00000000);
        `CHK("control read", 32'h00000000, rd)
        sleep_select_n <= 1'b1;
        repeat (12) sample(10'h0C3, 1'b0, 1'b0);
        `CHK("resumed", 1'b1, i_cap.words.size() > n)
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        tick(10);
        resetn <= 1'b1;
        tick(4);
        run_check(1'b1, 1'b1, 1'b1, 10'h100);
        run_check(1'b1, 1'b0, 1'b1, 10'h140);
        run_check(1'b1, 1'b1, 1'b0, 10'h180);
        run_check(1'b0, 1'b1, 1'b1, 10'h1C0);
        run_check(1'b0, 1'b0, 1'b0, 10'h200);
        self_test(1'b1, 1'b1);
        self_test(1'b0, 1'b0);
        sleep_and_fill();
        conclude();
    end

    // watchdog, several times the expected run length
    initial begin
        tick(60000);
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
